// *** design/msc_pkg.sv ***
package msc_pkg;

  // Data path widths and depths
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FREQ_W = 32;
  localparam int DEC_W = 8;
  localparam int PHASE_OUT_W = 12;

  // Counts of words and samples
  localparam logic [7:0] OWN_FRAME_LEN = 8'h08;
  localparam logic [15:0] BLOCK_LEN = 16'h0040;

  // Values after reset
  localparam logic [DEC_W-1:0] DEC_RESET = 8'h00;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h00000000;
  localparam logic [FREQ_W-1:0] PHASE_RESET = 32'h00000000;

  // Measurement loop states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_MEAS = 2'b10
  } msc_state_t;

  // Rightward frame assembly states
  typedef enum logic [2:0]
  {
    LB_IDLE = 3'b000,
    LB_OWN_HEAD = 3'b001,
    LB_PASS = 3'b010,
    LB_OWN_TAIL = 3'b011,
    LB_OWN_ONLY = 3'b100
  } msc_lb_state_t;

  // One word on the rightward local bus
  typedef struct packed
  {
    logic last;
    logic [DATA_W-1:0] data;
  } msc_lb_word_t;

endpackage : msc_pkg

// *** design/msc_sync_change.sv ***
`timescale 1ns/1ps

// Synchronous FIFO with valid and ready on both sides
module msc_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;

  // Full when pointers differ only in the wrap bit
  assign o_wr_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign o_rd_valid = (wr_ptr != rd_ptr);
  assign o_rd_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = i_rd_ready && o_rd_valid;

  // Pointer advance
  always_comb
  begin
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_clk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= i_wr_data;
  end
endmodule : msc_fifo

// Per-module synchronized filter and frequency change control
module msc_sync_change
  import msc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_filt_prep,
  input wire logic i_freq_prep,
  input wire logic [FREQ_W-1:0] i_freq_word,
  input wire logic i_cont_mode,
  input wire logic i_arm_en,
  input wire logic i_stop,
  input wire logic i_trigger,
  input wire logic i_all_idle,
  input wire logic i_sync_assert,
  input wire logic [2:0] i_dec_shift,
  input wire logic i_sync,
  output logic o_sync_out,
  output logic o_sync_oe_n,
  input wire logic [DATA_W-1:0] i_sample,
  input wire logic i_port_lbus,
  input wire logic i_lb_prepend,
  input wire logic i_vme_ack,
  output logic o_vme_valid,
  output logic [DATA_W-1:0] o_vme_data,
  input wire msc_lb_word_t i_left_word,
  input wire logic i_left_valid,
  output logic o_left_ready,
  output msc_lb_word_t o_right_word,
  output logic o_right_valid,
  input wire logic i_right_ready,
  output logic [1:0] o_state,
  output logic o_filt_pend,
  output logic o_freq_pend,
  output logic o_overflow,
  output logic [PHASE_OUT_W-1:0] o_lo_phase
);
  msc_state_t state, next_state;
  msc_lb_state_t lb_state, next_lb_state;
  logic sync_prev;
  logic sync_edge;
  logic filt_pend, next_filt_pend;
  logic freq_pend, next_freq_pend;
  logic [FREQ_W-1:0] freq_pending_word, next_freq_pending_word;
  logic [FREQ_W-1:0] freq, next_freq;
  logic [FREQ_W-1:0] phase, next_phase;
  logic [DEC_W-1:0] dec_cnt, next_dec_cnt;
  logic [DEC_W-1:0] dec_mask;
  logic dec_tick;
  logic [15:0] blk_cnt, next_blk_cnt;
  logic block_done;
  logic overflow, next_overflow;
  logic sync_drive, next_sync_drive;
  logic sync_oe_n, next_sync_oe_n;
  logic fifo_wr_valid, fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
  logic [DATA_W-1:0] fifo_rd_data;
  logic vme_valid, next_vme_valid;
  logic [DATA_W-1:0] vme_data, next_vme_data;
  msc_lb_word_t right_word, next_right_word;
  logic right_valid, next_right_valid;
  logic left_ready, next_left_ready;
  logic [7:0] own_cnt, next_own_cnt;
  logic slot_free;
  logic own_pop;
  logic left_take;

  // SYNC is a wired shared line sampled on the common ADC clock
  assign sync_edge = (i_sync != sync_prev);
  assign dec_mask = DEC_W'((9'h001 << i_dec_shift) - 9'h001);
  assign dec_tick = ((dec_cnt & dec_mask) == DEC_RESET);
  assign block_done = (blk_cnt == BLOCK_LEN);
  assign fifo_wr_valid = (state == ST_MEAS) && dec_tick && !(block_done && !i_cont_mode);

  // Measurement loop, pending changes, decimation and oscillator
  always_comb
  begin
    next_state = state;
    next_filt_pend = filt_pend || i_filt_prep;
    next_freq_pend = freq_pend || i_freq_prep;
    next_freq_pending_word = i_freq_prep ? i_freq_word : freq_pending_word;
    next_freq = freq;
    next_phase = phase + freq;
    next_dec_cnt = dec_cnt + 1'b1;
    next_blk_cnt = blk_cnt;
    next_overflow = overflow;
    // Loop progress
    unique case (state)
      ST_IDLE:
        if (sync_edge && i_arm_en)
          next_state = ST_ARM;
      ST_ARM:
        if (i_trigger)
        begin
          next_state = ST_MEAS;
          next_blk_cnt = '0;
          next_overflow = 1'b0;
        end
      ST_MEAS:
      begin
        if (fifo_wr_valid && fifo_wr_ready)
          next_blk_cnt = blk_cnt + 1'b1;
        if (fifo_wr_valid && !fifo_wr_ready)
        begin
          next_overflow = 1'b1;
          next_state = ST_IDLE;
        end
        else if (i_stop || (!i_cont_mode && block_done))
          next_state = ST_IDLE;
      end
    endcase
    // Filter resync preparation aborts the measurement
    if (i_filt_prep)
      next_state = ST_IDLE;
    // Filter resync on the SYNC transition
    if (sync_edge && filt_pend)
    begin
      next_dec_cnt = DEC_RESET;
      next_filt_pend = i_filt_prep;
    end
    // Frequency change only on the SYNC transition
    if (sync_edge && freq_pend && !i_filt_prep)
    begin
      if (state == ST_IDLE && (i_cont_mode || i_all_idle))
      begin
        next_freq = freq_pending_word;
        next_phase = PHASE_RESET;
        next_state = ST_ARM;
        next_freq_pend = i_freq_prep;
      end
      else if (state == ST_MEAS && i_cont_mode)
      begin
        next_freq = freq_pending_word;
        next_phase = PHASE_RESET;
        next_freq_pend = i_freq_prep;
      end
    end
  end

  // SYNC drive: block measurement holds it until its block is in
  always_comb
  begin
    next_sync_drive = i_sync_assert || (next_state == ST_MEAS && !i_cont_mode && !block_done);
    next_sync_oe_n = !next_sync_drive;
  end

  // Loop registers
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= ST_IDLE;
      filt_pend <= 1'b0;
      freq_pend <= 1'b0;
      freq_pending_word <= FREQ_RESET;
      freq <= FREQ_RESET;
      phase <= PHASE_RESET;
      dec_cnt <= DEC_RESET;
      blk_cnt <= '0;
      overflow <= 1'b0;
      sync_drive <= 1'b0;
      sync_oe_n <= 1'b1;
      sync_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      filt_pend <= next_filt_pend;
      freq_pend <= next_freq_pend;
      freq_pending_word <= next_freq_pending_word;
      freq <= next_freq;
      phase <= next_phase;
      dec_cnt <= next_dec_cnt;
      blk_cnt <= next_blk_cnt;
      overflow <= next_overflow;
      sync_drive <= next_sync_drive;
      sync_oe_n <= next_sync_oe_n;
      sync_prev <= i_sync;
    end
  end

  // Sample buffer between acquisition and the output ports
  msc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_wr_valid(fifo_wr_valid),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data(i_sample),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_rd_ready),
    .o_rd_data(fifo_rd_data)
  );

  assign slot_free = !right_valid || i_right_ready;
  assign own_pop = i_port_lbus && slot_free && fifo_rd_valid
    && (lb_state == LB_OWN_HEAD || lb_state == LB_OWN_TAIL || lb_state == LB_OWN_ONLY);
  assign left_take = left_ready && i_left_valid;
  assign fifo_rd_ready = own_pop || (!i_port_lbus && (!vme_valid || i_vme_ack));

  // VME port: one 16-bit word per transfer
  always_comb
  begin
    next_vme_valid = vme_valid && !i_vme_ack;
    next_vme_data = vme_data;
    if (!i_port_lbus && fifo_rd_valid && (!vme_valid || i_vme_ack))
    begin
      next_vme_valid = 1'b1;
      next_vme_data = fifo_rd_data;
    end
  end

  // Local bus: own words and forwarded left frames, rightward only
  always_comb
  begin
    next_lb_state = lb_state;
    next_own_cnt = own_cnt;
    next_right_valid = right_valid && !i_right_ready;
    next_right_word = right_word;
    unique case (lb_state)
      LB_IDLE:
      begin
        next_own_cnt = '0;
        if (i_left_valid && i_port_lbus)
          next_lb_state = i_lb_prepend ? LB_OWN_HEAD : LB_PASS;
        else if (fifo_rd_valid && i_port_lbus)
          next_lb_state = LB_OWN_ONLY;
      end
      LB_PASS:
        if (left_take)
        begin
          next_right_valid = 1'b1;
          next_right_word.data = i_left_word.data;
          next_right_word.last = i_left_word.last && i_lb_prepend;
          if (i_left_word.last)
            next_lb_state = i_lb_prepend ? LB_IDLE : LB_OWN_TAIL;
        end
      LB_OWN_HEAD, LB_OWN_TAIL, LB_OWN_ONLY:
        if (own_pop)
        begin
          next_own_cnt = own_cnt + 1'b1;
          next_right_valid = 1'b1;
          next_right_word.data = fifo_rd_data;
          next_right_word.last = (own_cnt == OWN_FRAME_LEN - 8'h01) && (lb_state != LB_OWN_HEAD);
          if (own_cnt == OWN_FRAME_LEN - 8'h01)
          begin
            next_own_cnt = '0;
            next_lb_state = (lb_state == LB_OWN_HEAD) ? LB_PASS : LB_IDLE;
          end
        end
      default:
        next_lb_state = LB_IDLE;
    endcase
    next_left_ready = (next_lb_state == LB_PASS) && !next_right_valid;
  end

  // Output port registers
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lb_state <= LB_IDLE;
      own_cnt <= '0;
      right_valid <= 1'b0;
      right_word <= '0;
      left_ready <= 1'b0;
      vme_valid <= 1'b0;
      vme_data <= '0;
    end
    else
    begin
      lb_state <= next_lb_state;
      own_cnt <= next_own_cnt;
      right_valid <= next_right_valid;
      right_word <= next_right_word;
      left_ready <= next_left_ready;
      vme_valid <= next_vme_valid;
      vme_data <= next_vme_data;
    end
  end

  // All outputs straight from flops
  assign o_sync_out = sync_drive;
  assign o_sync_oe_n = sync_oe_n;
  assign o_vme_valid = vme_valid;
  assign o_vme_data = vme_data;
  assign o_right_word = right_word;
  assign o_right_valid = right_valid;
  assign o_left_ready = left_ready;
  assign o_state = state;
  assign o_filt_pend = filt_pend;
  assign o_freq_pend = freq_pend;
  assign o_overflow = overflow;
  assign o_lo_phase = phase[FREQ_W-1 -: PHASE_OUT_W];
endmodule : msc_sync_change

// *** verif/msc_sync_change_sva.sv ***
`timescale 1ns/1ps
// Port-level checks of the synchronized change control
module msc_sync_change_sva
  import msc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_filt_prep,
  input wire logic i_freq_prep,
  input wire logic i_cont_mode,
  input wire logic i_arm_en,
  input wire logic i_stop,
  input wire logic i_all_idle,
  input wire logic i_sync_assert,
  input wire logic i_sync,
  input wire logic o_sync_oe_n,
  input wire logic i_vme_ack,
  input wire logic o_vme_valid,
  input wire logic [DATA_W-1:0] o_vme_data,
  input wire msc_lb_word_t o_right_word,
  input wire logic o_right_valid,
  input wire logic i_right_ready,
  input wire logic [1:0] o_state,
  input wire logic o_filt_pend,
  input wire logic o_freq_pend
);
  logic sync_q;
  logic sedge;
  // Previous SYNC level, any change is an event
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      sync_q <= 1'h0;
    else
      sync_q <= i_sync;
  end
  assign sedge = i_sync != sync_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  filt_idle_a: assert property (i_filt_prep |=> o_state == 2'h0 && o_filt_pend)
    else $error("filter prep did not idle");
  filt_sync_a: assert property (o_filt_pend && sedge && !i_filt_prep |=> !o_filt_pend)
    else $error("filter pend not cleared by sync");
  freq_wait_a: assert property (o_freq_pend && !sedge && !i_freq_prep |=> o_freq_pend)
    else $error("freq change applied without sync");
  idle_arm_a: assert property (o_state == 2'h0 && o_freq_pend && sedge && i_arm_en && !i_filt_prep && !i_freq_prep
    && (i_cont_mode || i_all_idle) |=> o_state == 2'h1 && !o_freq_pend)
    else $error("idle sync did not arm");
  cont_run_a: assert property (o_state == 2'h2 && i_cont_mode && o_freq_pend && sedge && !i_filt_prep && !i_freq_prep
    && !i_stop |=> o_state == 2'h2 && !o_freq_pend)
    else $error("continuous measure interrupted");
  block_skip_a: assert property (!i_cont_mode && !i_all_idle && o_freq_pend && !i_freq_prep |=> o_freq_pend)
    else $error("block mode took freq sync");
  right_hold_a: assert property (o_right_valid && !i_right_ready |=> o_right_valid && $stable(o_right_word))
    else $error("right word dropped");
  vme_hold_a: assert property (o_vme_valid && !i_vme_ack |=> o_vme_valid && $stable(o_vme_data))
    else $error("vme word dropped");
  sync_drive_a: assert property (i_sync_assert |=> !o_sync_oe_n)
    else $error("sync not driven");
  sync_arm_a: assert property (o_state == 2'h0 && sedge && i_arm_en && !i_filt_prep |=> o_state == 2'h1)
    else $error("sync did not arm");
endmodule : msc_sync_change_sva
bind msc_sync_change msc_sync_change_sva u_sva (.*);

// *** verif/msc_sink.sv ***
`timescale 1ns/1ps
// Downstream processor: mode 0 fast, 1 every other cycle, 2 stalled
module msc_sink
  import msc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_mode,
  input wire msc_lb_word_t i_word,
  input wire logic i_valid,
  output logic o_ready,
  output logic [15:0] o_frames
);
  logic tog;
  // Pace toggle and count of whole frames taken
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tog <= 1'h0;
      o_frames <= 16'h0000;
    end
    else
    begin
      tog <= !tog;
      if (i_valid && o_ready && i_word.last)
        o_frames <= o_frames + 16'h0001;
    end
  end
  assign o_ready = (i_mode == 2'h0) || (i_mode == 2'h1 && tog);
endmodule : msc_sink

// *** verif/msc_sync_change_tb.sv ***
`timescale 1ns/1ps
module msc_sync_change_tb;
  import msc_pkg::*;
  logic i_clk, i_rstn, i_filt_prep, i_freq_prep, i_cont_mode, i_arm_en, i_stop, i_trigger, i_all_idle;
  logic i_sync_assert, i_sync, i_port_lbus, i_lb_prepend, i_vme_ack, i_left_valid, i_right_ready;
  logic o_sync_out, o_sync_oe_n, o_vme_valid, o_left_ready, o_right_valid, o_filt_pend, o_freq_pend, o_overflow;
  logic [FREQ_W-1:0] i_freq_word;
  logic [2:0] i_dec_shift;
  logic [DATA_W-1:0] i_sample, o_vme_data;
  msc_lb_word_t i_left_word, o_right_word;
  msc_lb_word_t q[$];
  logic [1:0] o_state, smode;
  logic [PHASE_OUT_W-1:0] o_lo_phase, ph;
  logic [15:0] frames;
  int miscompares, n_checks, vcnt, k;
  msc_sync_change DUT (.*);
  msc_sink p (.i_clk, .i_rstn, .i_mode(smode), .i_word(o_right_word), .i_valid(o_right_valid),
    .o_ready(i_right_ready), .o_frames(frames));
  // Clock and logs of words taken on both ports
  always #20 i_clk = !i_clk;
  always @(posedge i_clk)
  begin
    if (o_vme_valid === 1'h1 && i_vme_ack === 1'h1)
      vcnt++;
    if (o_right_valid === 1'h1 && i_right_ready === 1'h1)
      q.push_back(o_right_word);
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic ck(input bit ok, input string m);
  begin
    n_checks++;
    if (!ok)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  end
  endtask : ck
  task automatic tog;
  begin
    i_sync = !i_sync;
    cyc(1);
  end
  endtask : tog
  task automatic wait_st(input logic [1:0] s);
    int n;
  begin
    n = 0;
    while (o_state !== s && n < 300)
    begin
      cyc(1);
      n++;
    end
  end
  endtask : wait_st
  // Hold a left word until the edge at which ready is seen high
  task automatic send_left(input msc_lb_word_t w);
  begin
    i_left_word = w;
    i_left_valid = 1'h1;
    while (o_left_ready !== 1'h1)
      cyc(1);
    cyc(1);
  end
  endtask : send_left
  task automatic t_filt;
  begin
    i_sync_assert = 1'h1;
    cyc(2);
    ck(o_sync_oe_n === 1'h0 && o_sync_out === 1'h1, "sync not driven");
    i_sync_assert = 1'h0;
    i_filt_prep = 1'h1;
    cyc(1);
    i_filt_prep = 1'h0;
    ck(o_state === 2'h0 && o_filt_pend === 1'h1, "filter prep");
    cyc(3);
    ck(o_filt_pend === 1'h1, "filter pend lost");
    tog;
    ck(o_filt_pend === 1'h0, "filter pend kept");
  end
  endtask : t_filt
  task automatic t_freq;
  begin
    i_freq_word = 32'h01000000;
    i_freq_prep = 1'h1;
    cyc(1);
    i_freq_prep = 1'h0;
    tog;
    ck(o_freq_pend === 1'h1 && o_state === 2'h0, "block sync taken");
    i_all_idle = 1'h1;
    i_arm_en = 1'h1;
    tog;
    ck(o_state === 2'h1 && o_freq_pend === 1'h0, "idle sync");
    ph = o_lo_phase;
    cyc(1);
    ck(ph === 12'h000 && o_lo_phase === 12'h010, "oscillator phase");
  end
  endtask : t_freq
  task automatic t_cont;
  begin
    i_cont_mode = 1'h1;
    i_trigger = 1'h1;
    wait_st(2'h2);
    i_freq_word = 32'h00800000;
    i_freq_prep = 1'h1;
    cyc(1);
    i_freq_prep = 1'h0;
    k = vcnt;
    tog;
    ck(o_state === 2'h2 && o_freq_pend === 1'h0, "continuous sync");
    cyc(20);
    ck(vcnt > k, "no vme words");
    ck(o_vme_valid === 1'h1 && o_vme_data === 16'h0055, "vme data");
    i_stop = 1'h1;
    cyc(1);
    i_stop = 1'h0;
    wait_st(2'h0);
  end
  endtask : t_cont
  task automatic t_lbus;
  begin
    i_port_lbus = 1'h1;
    i_dec_shift = 3'h2;
    smode = 2'h1;
    tog;
    wait_st(2'h2);
    send_left(17'h0C001);
    send_left(17'h1C002);
    i_left_valid = 1'h0;
    cyc(60);
    k = -1;
    foreach (q[i])
      if (q[i].data === 16'hC002)
        k = i;
    ck(k > 8 && q[k] === 17'h1C002 && q[k-1] === 17'h0C001, "left frame");
    ck(k > 8 && q[k-2] === 17'h00055 && frames !== 16'h0000, "own head");
    // Append mode: left frame first with its last cleared, own words after
    i_lb_prepend = 1'h0;
    send_left(17'h1C003);
    i_left_valid = 1'h0;
    cyc(60);
    k = -1;
    foreach (q[i])
      if (q[i].data === 16'hC003)
        k = i;
    ck(k > 0 && q[k] === 17'h0C003 && q[k+7] === 17'h00055 && q[k+8] === 17'h10055, "own tail");
    ck(o_overflow === 1'h0, "early overflow");
    smode = 2'h2;
    wait_st(2'h0);
    ck(o_overflow === 1'h1, "no overflow");
    smode = 2'h0;
    cyc(60);
    ck(o_right_valid === 1'h0, "not drained");
  end
  endtask : t_lbus
  task automatic end_sim;
  begin
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : end_sim
  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    miscompares++;
    end_sim;
  end
  // Reset then scenarios in order
  initial
  begin
    {i_clk, i_rstn, i_filt_prep, i_freq_prep, i_cont_mode, i_arm_en, i_stop, i_trigger, i_all_idle} = 9'h000;
    {i_sync_assert, i_sync, i_port_lbus, i_vme_ack, i_left_valid, smode} = 7'h00;
    {i_freq_word, i_dec_shift, i_left_word} = 52'h0;
    i_lb_prepend = 1'h1;
    i_sample = 16'h0055;
    cyc(6);
    i_rstn = 1'h1;
    i_vme_ack = 1'h1;
    cyc(1);
    t_filt;
    t_freq;
    t_cont;
    t_lbus;
    end_sim;
  end
endmodule : msc_sync_change_tb
